// ==== hdlc_tac_pkg.sv ====
// Constants shared by the timing and address control block.
package hdlc_tac_pkg;
  localparam logic [7:0] ADDR_RSA = 8'h00;
  localparam logic [7:0] ADDR_CTB = 8'h04;
  localparam logic [7:0] ADDR_TMC = 8'h08;
  localparam logic [7:0] ADDR_IFR = 8'h0c;
  localparam logic [7:0] ADDR_IMR = 8'h10;
  localparam logic [7:0] ADDR_CTL = 8'h14;
  localparam logic [7:0] ADDR_CST = 8'h18;
  localparam logic [7:0] ADDR_RST = 8'h1c;
  localparam int TMC_RST = 7;
  localparam int TMC_IC = 6;
  localparam int TMC_SIDE_SLOT_OUTPUT_ENABLE = 5;
  localparam int TMC_BIT_RATE_CLOCK_SELECT = 4;
  localparam int TMC_TC3 = 3;
  localparam int CTL_AME = 0;
  localparam int CTL_SIX = 1;
  localparam int IFR_GA = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] RSA_RESET = 7'h00;
  localparam logic [1:0] CTL_RESET = 2'h0;
  localparam logic [7:0] GO_AHEAD_PATTERN = 8'h7f;
  localparam logic [7:0] FRAME_FIRST_BIT = 8'h00;
  localparam logic [4:0] SIDE_CHANNEL = 5'h01;
  localparam logic [4:0] CHAN0 = 5'h00;
  localparam logic [4:0] CHAN2 = 5'h02;
  localparam logic [4:0] CHAN3 = 5'h03;
  localparam logic [4:0] CHAN4 = 5'h04;
  localparam logic [2:0] LAST_BIT_POS = 3'h7;
  localparam logic [3:0] PART1_BITS = 4'h1;
  localparam logic [3:0] PART2_BITS = 4'h2;
  localparam logic [3:0] PART6_BITS = 4'h6;
  localparam logic [3:0] PART7_BITS = 4'h7;
  localparam logic [1:0] CLEARS_TO_LEAVE = 2'h2;
  typedef enum logic [2:0] {
    TC_P1, TC_P2, TC_P67, TC_C2, TC_C3, TC_C4, TC_C23, TC_C234
  } tc_code_t;
endpackage

// ==== sync2.sv ====
// Two flip-flop synchroniser for a group of levels.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule // sync2

// ==== hdlc_timing_and_address_control.sv ====
// Timing, address and interrupt-flag control of the serial packet controller.
// Functional notes
// - With address matching on, accept packets whose upper 7 or 6 bits match or all-call.
// - Address register bit zero reads zero and takes no part in comparison.
// - Side-channel byte goes out in channel 1 only when enabled and internally timed.
// - Software reset clears all registers and FIFOs, keeping its own bit.
// - Reset is left only after the second write of zero to the reset bit.
// - External timing gates sections with the enable pins; frame pulse unused here.
// - Internal timing derives slot enables from clock and frame pulse, ignoring pins.
// - Channel-1 enable high drives side byte; low floats the output in that slot.
// - Internal timing captures every incoming channel-1 byte into the status register.
// - Bit-rate select high means clock at bit rate, low means twice bit rate.
// - Codes 000, 001, 010 enable 1, 2, 6 or 7 bits of channel 0.
// - Codes 011 to 111 enable channels 2, 3, 4, 2+3 or 2+3+4.
// - Reading the interrupt flags clears them all until their events recur.
// - Go-ahead flag bit 7 is set when a go-ahead sequence is received.
// - All-call means every compared upper address bit is one.
// - Go-ahead is recognised as the received byte pattern 7F hex.
// - Masked flags still set and read but do not raise the interrupt.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module hdlc_timing_and_address_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_clock_in,
  input wire logic frame_pulse_n,
  input wire logic serial_data_in,
  input wire logic tx_section_enable_n,
  input wire logic rx_section_enable_n,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic tx_bit,
  output logic tx_bit_take,
  output logic rx_bit,
  output logic rx_bit_valid,
  input wire logic [7:0] addr_byte,
  input wire logic addr_valid,
  output logic packet_accept,
  output logic packet_reject,
  input wire logic [6:0] flag_events,
  output logic fifo_flush,
  output logic irq,
  output logic irq_n
);
  logic [6:0] rsa_ff;
  logic [7:0] ctb_ff;
  logic [7:0] tmc_ff;
  logic [7:0] ifr_ff;
  logic [7:0] imr_ff;
  logic [1:0] ctl_ff;
  logic [7:0] cst_ff;
  logic soft_rst_ff;
  logic [1:0] clears_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic [4:0] pins_s;
  logic ck_s, fp_n_s, din_s, txen_n_s, rxen_n_s;
  logic ck_d_ff;
  logic half_ff;
  logic [7:0] bit_cnt_ff;
  logic [7:0] rx_shift_ff;
  logic [7:0] cin_ff;
  logic sdo_ff, sdo_oe_ff, take_ff, rbit_ff, rvalid_ff, acc_ff, rej_ff;
  logic acc, wr, rd, hit, ga_event;
  logic ck_fall, bit_edge;
  logic internal, cur_slot, cur_side;
  logic [7:0] nxt_bit;
  logic [7:0] nxt_ifr;
  logic [7:0] ifr_clr;
  logic [7:0] rdata;
  logic [7:0] nxt_shift;
  logic addr_match;

  // Data-slot decode for one bit position of the frame.
  function automatic logic data_slot(input logic [7:0] b, input logic [3:0] tc);
    logic [4:0] ch;
    logic [3:0] pos;
    ch = b[7:3];
    pos = {1'b0, b[2:0]};
    data_slot = 1'b0;
    unique case (hdlc_tac_pkg::tc_code_t'(tc[2:0]))
      hdlc_tac_pkg::TC_P1: data_slot = (ch == hdlc_tac_pkg::CHAN0) && (pos < hdlc_tac_pkg::PART1_BITS);
      hdlc_tac_pkg::TC_P2: data_slot = (ch == hdlc_tac_pkg::CHAN0) && (pos < hdlc_tac_pkg::PART2_BITS);
      hdlc_tac_pkg::TC_P67: data_slot = (ch == hdlc_tac_pkg::CHAN0) &&
        (pos < (tc[hdlc_tac_pkg::TMC_TC3] ? hdlc_tac_pkg::PART7_BITS : hdlc_tac_pkg::PART6_BITS));
      hdlc_tac_pkg::TC_C2: data_slot = (ch == hdlc_tac_pkg::CHAN2);
      hdlc_tac_pkg::TC_C3: data_slot = (ch == hdlc_tac_pkg::CHAN3);
      hdlc_tac_pkg::TC_C4: data_slot = (ch == hdlc_tac_pkg::CHAN4);
      hdlc_tac_pkg::TC_C23: data_slot = (ch == hdlc_tac_pkg::CHAN2) || (ch == hdlc_tac_pkg::CHAN3);
      hdlc_tac_pkg::TC_C234: data_slot = (ch == hdlc_tac_pkg::CHAN2) || (ch == hdlc_tac_pkg::CHAN3) ||
        (ch == hdlc_tac_pkg::CHAN4);
    endcase
  endfunction

  // Bus transfers complete on the second access cycle, one wait state.
  assign acc = psel && penable && pready_ff;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  always_comb begin
    hit = 1'b1;
    rdata = hdlc_tac_pkg::REG_RESET;
    unique case (paddr)
      hdlc_tac_pkg::ADDR_RSA: rdata = {rsa_ff, 1'b0};
      hdlc_tac_pkg::ADDR_CTB: rdata = ctb_ff;
      hdlc_tac_pkg::ADDR_TMC: rdata = tmc_ff;
      hdlc_tac_pkg::ADDR_IFR: rdata = ifr_ff;
      hdlc_tac_pkg::ADDR_IMR: rdata = imr_ff;
      hdlc_tac_pkg::ADDR_CTL: rdata = {6'h00, ctl_ff};
      hdlc_tac_pkg::ADDR_CST: rdata = cst_ff;
      hdlc_tac_pkg::ADDR_RST: rdata = {7'h00, soft_rst_ff};
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !hit;
      prdata_ff <= {24'h000000, rdata};
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
  end

  // Software reset state: entered by a one, left after two writes of zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_rst_ff <= 1'b0;
      clears_ff <= 2'h0;
    end else if (wr && paddr == hdlc_tac_pkg::ADDR_TMC) begin
      if (pwdata[hdlc_tac_pkg::TMC_RST]) begin
        soft_rst_ff <= 1'b1;
        clears_ff <= 2'h0;
      end else if (soft_rst_ff) begin
        clears_ff <= clears_ff + 2'h1;
        if (clears_ff + 2'h1 == hdlc_tac_pkg::CLEARS_TO_LEAVE) begin
          soft_rst_ff <= 1'b0;
        end
      end
    end
  end
  assign fifo_flush = soft_rst_ff;

  // The reset bit keeps its written value; the other bits stay clear in reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmc_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (wr && paddr == hdlc_tac_pkg::ADDR_TMC) begin
      if (soft_rst_ff || pwdata[hdlc_tac_pkg::TMC_RST]) begin
        tmc_ff <= {pwdata[hdlc_tac_pkg::TMC_RST], 7'h00};
      end else begin
        tmc_ff <= pwdata[7:0];
      end
    end else if (soft_rst_ff) begin
      tmc_ff <= {tmc_ff[hdlc_tac_pkg::TMC_RST], 7'h00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsa_ff <= hdlc_tac_pkg::RSA_RESET;
      ctb_ff <= hdlc_tac_pkg::REG_RESET;
      imr_ff <= hdlc_tac_pkg::REG_RESET;
      ctl_ff <= hdlc_tac_pkg::CTL_RESET;
    end else if (soft_rst_ff) begin
      rsa_ff <= hdlc_tac_pkg::RSA_RESET;
      ctb_ff <= hdlc_tac_pkg::REG_RESET;
      imr_ff <= hdlc_tac_pkg::REG_RESET;
      ctl_ff <= hdlc_tac_pkg::CTL_RESET;
    end else if (wr) begin
      if (paddr == hdlc_tac_pkg::ADDR_RSA) begin
        rsa_ff <= pwdata[7:1];
      end
      if (paddr == hdlc_tac_pkg::ADDR_CTB) begin
        ctb_ff <= pwdata[7:0];
      end
      if (paddr == hdlc_tac_pkg::ADDR_IMR) begin
        imr_ff <= pwdata[7:0];
      end
      if (paddr == hdlc_tac_pkg::ADDR_CTL) begin
        ctl_ff <= pwdata[1:0];
      end
    end
  end

  // Interrupt flags: a read clears all, a write of ones clears those; a new event wins.
  always_comb begin
    ifr_clr = 8'h00;
    if (rd && paddr == hdlc_tac_pkg::ADDR_IFR) begin
      ifr_clr = 8'hff;
    end else if (wr && paddr == hdlc_tac_pkg::ADDR_IFR) begin
      ifr_clr = pwdata[7:0];
    end
    nxt_ifr = (ifr_ff & ~ifr_clr) | {ga_event, flag_events};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ifr_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (soft_rst_ff) begin
      ifr_ff <= hdlc_tac_pkg::REG_RESET;
    end else begin
      ifr_ff <= nxt_ifr;
    end
  end

  assign irq = |(ifr_ff & imr_ff);
  assign irq_n = !irq;

  // Address recognition on the address byte delivered by the receiver.
  always_comb begin
    if (ctl_ff[hdlc_tac_pkg::CTL_SIX]) begin
      addr_match = (addr_byte[7:2] == rsa_ff[6:1]) || (&addr_byte[7:2]);
    end else begin
      addr_match = (addr_byte[7:1] == rsa_ff) || (&addr_byte[7:1]);
    end
    if (!ctl_ff[hdlc_tac_pkg::CTL_AME]) begin
      addr_match = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_ff <= 1'b0;
      rej_ff <= 1'b0;
    end else begin
      acc_ff <= addr_valid && addr_match && !soft_rst_ff;
      rej_ff <= addr_valid && !addr_match && !soft_rst_ff;
    end
  end
  assign packet_accept = acc_ff;
  assign packet_reject = rej_ff;

  // Link pins are brought into the bus clock domain.
  sync2 #(.W(5)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({serial_clock_in, frame_pulse_n, serial_data_in, tx_section_enable_n, rx_section_enable_n}),
    .q(pins_s)
  );
  assign {ck_s, fp_n_s, din_s, txen_n_s, rxen_n_s} = pins_s;

  assign internal = tmc_ff[hdlc_tac_pkg::TMC_IC];
  assign ck_fall = ck_d_ff && !ck_s;
  // At twice the bit rate only every second falling edge ends a bit; a frame-start edge always does.
  assign bit_edge = ck_fall && (!internal || tmc_ff[hdlc_tac_pkg::TMC_BIT_RATE_CLOCK_SELECT] || half_ff || !fp_n_s);

  always_comb begin
    if (!fp_n_s) begin
      nxt_bit = hdlc_tac_pkg::FRAME_FIRST_BIT;
    end else begin
      nxt_bit = bit_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_d_ff <= 1'b0;
      half_ff <= 1'b0;
      bit_cnt_ff <= hdlc_tac_pkg::FRAME_FIRST_BIT;
    end else begin
      ck_d_ff <= ck_s;
      if (soft_rst_ff || !internal) begin
        half_ff <= 1'b0;
        bit_cnt_ff <= hdlc_tac_pkg::FRAME_FIRST_BIT;
      end else if (ck_fall) begin
        half_ff <= !fp_n_s ? 1'b0 : !half_ff;
        if (bit_edge) begin
          bit_cnt_ff <= nxt_bit;
        end
      end
    end
  end

  assign cur_slot = data_slot(bit_cnt_ff, tmc_ff[3:0]);
  assign cur_side = bit_cnt_ff[7:3] == hdlc_tac_pkg::SIDE_CHANNEL;

  // Transmit side: a bit is presented at each enabled bit edge for the following period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sdo_ff <= 1'b0;
      sdo_oe_ff <= 1'b0;
      take_ff <= 1'b0;
    end else begin
      take_ff <= 1'b0;
      if (soft_rst_ff) begin
        sdo_ff <= 1'b0;
        sdo_oe_ff <= 1'b0;
      end else if (!internal) begin
        sdo_oe_ff <= !txen_n_s;
        if (bit_edge && !txen_n_s) begin
          sdo_ff <= tx_bit;
          take_ff <= 1'b1;
        end
      end else if (bit_edge) begin
        if (data_slot(nxt_bit, tmc_ff[3:0])) begin
          sdo_ff <= tx_bit;
          sdo_oe_ff <= 1'b1;
          take_ff <= 1'b1;
        end else if (nxt_bit[7:3] == hdlc_tac_pkg::SIDE_CHANNEL && tmc_ff[hdlc_tac_pkg::TMC_SIDE_SLOT_OUTPUT_ENABLE]) begin
          sdo_ff <= ctb_ff[hdlc_tac_pkg::LAST_BIT_POS - nxt_bit[2:0]];
          sdo_oe_ff <= 1'b1;
        end else begin
          sdo_ff <= 1'b0;
          sdo_oe_ff <= 1'b0;
        end
      end
    end
  end
  assign serial_data_out = sdo_ff;
  assign serial_data_oe = sdo_oe_ff;
  assign tx_bit_take = take_ff;

  // Receive side: the line is sampled at the end of each enabled bit period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rbit_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= 1'b0;
      if (!soft_rst_ff && bit_edge) begin
        if (internal ? cur_slot : !rxen_n_s) begin
          rbit_ff <= din_s;
          rvalid_ff <= 1'b1;
        end
      end
    end
  end
  assign rx_bit = rbit_ff;
  assign rx_bit_valid = rvalid_ff;

  // Side-channel capture runs whatever the output enable says.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cin_ff <= hdlc_tac_pkg::REG_RESET;
      cst_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (soft_rst_ff) begin
      cin_ff <= hdlc_tac_pkg::REG_RESET;
      cst_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (internal && bit_edge && cur_side) begin
      cin_ff <= {cin_ff[6:0], din_s};
      if (bit_cnt_ff[2:0] == hdlc_tac_pkg::LAST_BIT_POS) begin
        cst_ff <= {cin_ff[6:0], din_s};
      end
    end
  end

  // Go-ahead search over received data bits, first bit lands lowest.
  assign nxt_shift = {rbit_ff, rx_shift_ff[7:1]};
  assign ga_event = rvalid_ff && (nxt_shift == hdlc_tac_pkg::GO_AHEAD_PATTERN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (soft_rst_ff) begin
      rx_shift_ff <= hdlc_tac_pkg::REG_RESET;
    end else if (rvalid_ff) begin
      rx_shift_ff <= nxt_shift;
    end
  end
endmodule // hdlc_timing_and_address_control

// ==== hdlc_tac_props.sv ====
// Port-level assertions for the timing and address control block.
`timescale 1ns/1ps
module hdlc_tac_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_data_oe,
  input wire logic tx_bit_take,
  input wire logic rx_bit_valid,
  input wire logic addr_valid,
  input wire logic packet_accept,
  input wire logic packet_reject,
  input wire logic [6:0] flag_events,
  input wire logic fifo_flush,
  input wire logic irq,
  input wire logic irq_n
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access_start;
    psel && penable && !$past(penable);
  endsequence
  sequence s_one_wait;
    !pready ##1 pready;
  endsequence
  sequence s_quiet_flag_read;
    psel && penable && pready && !pwrite && paddr == hdlc_tac_pkg::ADDR_IFR && flag_events == 7'h00 && !rx_bit_valid;
  endsequence
  a_one_wait_state: assert property (s_access_start |-> s_one_wait) else $error("ready not in second access cycle");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error response");
  a_idle_read_data: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_address_answer: assert property (addr_valid && !fifo_flush |=> packet_accept != packet_reject)
    else $error("no verdict");
  a_address_cause: assert property ((packet_accept || packet_reject) |-> $past(addr_valid)) else $error("stray verdict");
  a_flag_read_clear: assert property (s_quiet_flag_read |=> !irq) else $error("flags survive read");
  a_flush_quiet: assert property (fifo_flush ##1 fifo_flush |-> !serial_data_oe && !tx_bit_take && !irq)
    else $error("active in reset");
  a_take_pulse: assert property (tx_bit_take |=> !tx_bit_take) else $error("take pulse too long");
  a_irq_polarity: assert property (irq_n == !irq) else $error("interrupt outputs disagree");
endmodule // hdlc_tac_props
bind hdlc_timing_and_address_control hdlc_tac_props i_props (.*);

// ==== serial_bus_partner.sv ====
// Model of the framed serial bus: bit clock, frame pulse, receive data and output monitor.
`timescale 1ns/1ps
module serial_bus_partner (
  input wire logic run,
  input wire logic double_rate,
  input wire logic [7:0] side_byte,
  input wire logic [7:0] data_byte,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  output logic serial_clock_in,
  output logic frame_pulse_n,
  output logic serial_data_in,
  output logic [8:0] oe_count,
  output logic [7:0] side_seen,
  output logic [7:0] frames
);
  logic [8:0] cnt;
  int p;
  int reps;
  initial begin
    serial_clock_in = 1'b1;
    frame_pulse_n = 1'b1;
    serial_data_in = 1'b0;
    oe_count = '0;
    side_seen = '0;
    frames = '0;
    cnt = '0;
    #3;
    forever begin
      if (run !== 1'b1) begin
        // The clock stands still outside frames while the data line keeps changing.
        serial_data_in = ~serial_data_in;
        #80;
      end else begin
        // A bit lasts two clock periods at twice the bit rate; the rate is fixed for a whole frame.
        reps = (double_rate === 1'b1) ? 2 : 1;
        for (int n = 0; n < 256; n++) begin
          for (int h = 0; h < reps; h++) begin
            if (n == 0 && h == 0) frame_pulse_n = 1'b0;
            #40 serial_clock_in = 1'b0;
            if (h == 0) begin
              // The bit that just ended is judged before the block can change its output.
              p = (n + 255) % 256;
              cnt = cnt + 9'(serial_data_oe === 1'b1);
              if (serial_data_oe === 1'b1 && p / 8 == 1) side_seen = {side_seen[6:0], serial_data_out};
              if (n == 0) begin
                oe_count = cnt;
                cnt = '0;
                frames = frames + 8'h1;
              end
            end
            #20 frame_pulse_n = 1'b1;
            #20 serial_clock_in = 1'b1;
            // Data moves half a clock after the boundary, so it stands across the sampling edge.
            if (h == 0) serial_data_in = (n / 8 == 1) ? side_byte[7 - n % 8] : data_byte[n % 8];
          end
        end
      end
    end
  end
endmodule // serial_bus_partner

// ==== hdlc_timing_and_address_control_tb.sv ====
// Self-checking bench for registers, address match, flags, soft reset and link slots.
`timescale 1ns/1ps
module hdlc_timing_and_address_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fp_n, sclk, sdi, sdo, sdo_oe, err;
  logic tx_en_n, rx_en_n, tx_bit, tx_take, rx_bit, rx_valid, addr_valid, acc, rej, flush, irq, irq_n, run, dbl;
  logic [7:0] paddr, addr_byte, side_seen, frames, rd;
  logic [31:0] pwdata, prdata;
  logic [6:0] flag_events;
  logic [8:0] oe_count;
  int n_errors, checks_done, cyc;
  logic [10:0] atab [8] = '{{2'd1, 8'h55, 1'b1}, {2'd1, 8'h56, 1'b0}, {2'd1, 8'hfe, 1'b1}, {2'd1, 8'hfc, 1'b0},
    {2'd3, 8'h56, 1'b1}, {2'd3, 8'hfc, 1'b1}, {2'd3, 8'h5c, 1'b0}, {2'd0, 8'h00, 1'b1}};
  logic [17:0] ltab [12] = '{{1'b1, 8'h50, 9'd1}, {1'b1, 8'h51, 9'd2}, {1'b1, 8'h52, 9'd6}, {1'b1, 8'h5a, 9'd7},
    {1'b1, 8'h53, 9'd8}, {1'b1, 8'h54, 9'd8}, {1'b1, 8'h55, 9'd8}, {1'b1, 8'h56, 9'd16}, {1'b1, 8'h57, 9'd24},
    {1'b0, 8'h00, 9'd256}, {1'b1, 8'h00, 9'd0}, {1'b1, 8'h77, 9'd32}};
  hdlc_timing_and_address_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(sclk), .frame_pulse_n(fp_n), .serial_data_in(sdi), .tx_section_enable_n(tx_en_n),
    .rx_section_enable_n(rx_en_n), .serial_data_out(sdo), .serial_data_oe(sdo_oe), .tx_bit(tx_bit),
    .tx_bit_take(tx_take), .rx_bit(rx_bit), .rx_bit_valid(rx_valid), .addr_byte(addr_byte),
    .addr_valid(addr_valid), .packet_accept(acc), .packet_reject(rej), .flag_events(flag_events),
    .fifo_flush(flush), .irq(irq), .irq_n(irq_n));
  serial_bus_partner i_bus (.run(run), .double_rate(dbl), .side_byte(8'h3c), .data_byte(8'h7f), .serial_data_out(sdo),
    .serial_data_oe(sdo_oe), .serial_clock_in(sclk), .frame_pulse_n(fp_n), .serial_data_in(sdi),
    .oe_count(oe_count), .side_seen(side_seen), .frames(frames));
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk({err, rd}, {1'b0, exp});
  endtask
  task automatic ev();
    flag_events <= 7'h04;
    @(posedge pclk);
    flag_events <= 7'h00;
    @(posedge pclk);
  endtask
  task automatic wait_frames();
    logic [7:0] f0;
    f0 = frames;
    while (frames != f0 + 8'h2) @(posedge pclk);
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) if (tx_take === 1'b1) tx_bit <= ~tx_bit;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      n_errors++;
      $display("ERROR at %0t: timeout", $time);
      summarize();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, tx_bit, addr_byte, addr_valid, flag_events, run, dbl} = '0;
    tx_en_n = 1'b1;
    rx_en_n = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(hdlc_tac_pkg::ADDR_CST, 8'hff);
    for (int i = 0; i < 8; i++) rdc(8'(4 * i), 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    chk({err, rd}, 9'h100);
    wr(hdlc_tac_pkg::ADDR_RSA, 8'hff);
    rdc(hdlc_tac_pkg::ADDR_RSA, 8'hfe);
    wr(hdlc_tac_pkg::ADDR_RSA, 8'h54);
    for (int i = 0; i < 8; i++) begin
      wr(hdlc_tac_pkg::ADDR_CTL, {6'h0, atab[i][10:9]});
      addr_byte <= atab[i][8:1];
      addr_valid <= 1'b1;
      @(posedge pclk);
      addr_valid <= 1'b0;
      @(posedge pclk);
      chk({acc, rej}, {atab[i][0], !atab[i][0]});
    end
    ev();
    chk(irq, 1'b0);
    rdc(hdlc_tac_pkg::ADDR_IFR, 8'h04);
    rdc(hdlc_tac_pkg::ADDR_IFR, 8'h00);
    ev();
    wr(hdlc_tac_pkg::ADDR_IMR, 8'h04);
    chk({irq, irq_n}, 2'b10);
    wr(hdlc_tac_pkg::ADDR_IFR, 8'h04);
    chk({irq, irq_n}, 2'b01);
    ev();
    rdc(hdlc_tac_pkg::ADDR_IFR, 8'h04);
    chk(irq, 1'b0);
    wr(hdlc_tac_pkg::ADDR_CTB, 8'h5a);
    wr(hdlc_tac_pkg::ADDR_TMC, 8'h80);
    chk(flush, 1'b1);
    wr(hdlc_tac_pkg::ADDR_CTB, 8'h33);
    rdc(hdlc_tac_pkg::ADDR_CTB, 8'h00);
    rdc(hdlc_tac_pkg::ADDR_IMR, 8'h00);
    rdc(hdlc_tac_pkg::ADDR_RSA, 8'h00);
    rdc(hdlc_tac_pkg::ADDR_TMC, 8'h80);
    wr(hdlc_tac_pkg::ADDR_TMC, 8'h00);
    chk(flush, 1'b1);
    wr(hdlc_tac_pkg::ADDR_TMC, 8'h00);
    chk(flush, 1'b0);
    wr(hdlc_tac_pkg::ADDR_CTB, 8'ha5);
    run <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      tx_en_n <= ltab[i][17];
      rx_en_n <= ltab[i][17];
      dbl <= ltab[i][15] && !ltab[i][13];
      wr(hdlc_tac_pkg::ADDR_TMC, ltab[i][16:9]);
      wait_frames();
      chk(oe_count, ltab[i][8:0]);
      if (i == 4) rdc(hdlc_tac_pkg::ADDR_IFR, 8'h80);
    end
    chk(side_seen, 8'ha5);
    rdc(hdlc_tac_pkg::ADDR_CST, 8'h3c);
    summarize();
  end
endmodule // hdlc_timing_and_address_control_tb
